// ---- logic/gpc_bank_if.sv ----
// carrier between the top and one port's sub-register bank
`timescale 1ns/1ns
interface gpc_bank_if;
  import gpc_pkg::*;
  logic idx_wr;
  logic win_wr;
  logic out_wr;
  gpc_byte_t wdata;
  gpc_byte_t index;
  gpc_byte_t dir;
  gpc_byte_t af;
  gpc_byte_t oc;
  gpc_byte_t hde;
  gpc_byte_t wake;
  gpc_byte_t pue;
  gpc_byte_t afs_lo;
  gpc_byte_t afs_hi;
  gpc_byte_t outd;
  gpc_byte_t win_rdata;

  modport bank (
    input idx_wr, win_wr, out_wr, wdata,
    output index, dir, af, oc, hde, wake, pue, afs_lo, afs_hi, outd, win_rdata
  );
  modport top (
    output idx_wr, win_wr, out_wr, wdata,
    input index, dir, af, oc, hde, wake, pue, afs_lo, afs_hi, outd, win_rdata
  );
endinterface : gpc_bank_if

// ---- logic/gpc_pkg.sv ----
// shared constants for the port pin configuration block
package gpc_pkg;

  localparam int GPC_DATA_W = 8;
  localparam int GPC_ALT_NUM = 4;

  typedef logic [GPC_DATA_W-1:0] gpc_byte_t;

  // sub-register indices selected through the port index register
  localparam gpc_byte_t GPC_IDX_NONE = 8'h00;
  localparam gpc_byte_t GPC_IDX_DIR = 8'h01;
  localparam gpc_byte_t GPC_IDX_AF = 8'h02;
  localparam gpc_byte_t GPC_IDX_OC = 8'h03;
  localparam gpc_byte_t GPC_IDX_HDE = 8'h04;
  localparam gpc_byte_t GPC_IDX_WAKE = 8'h05;
  localparam gpc_byte_t GPC_IDX_PUE = 8'h06;
  localparam gpc_byte_t GPC_IDX_AFS_LO = 8'h07;
  localparam gpc_byte_t GPC_IDX_AFS_HI = 8'h08;

  // register addresses: four bytes per port starting at the base
  localparam logic [11:0] GPC_BASE_ADDR = 12'hfd0;
  localparam logic [1:0] GPC_OFS_INDEX = 2'h0;
  localparam logic [1:0] GPC_OFS_WINDOW = 2'h1;
  localparam logic [1:0] GPC_OFS_INPUT = 2'h2;
  localparam logic [1:0] GPC_OFS_OUTPUT = 2'h3;

  // values after reset
  localparam gpc_byte_t GPC_RST_INDEX = 8'h00;
  localparam gpc_byte_t GPC_RST_DIR = 8'hff;
  localparam gpc_byte_t GPC_RST_AF = 8'h00;
  localparam gpc_byte_t GPC_RST_AF_SMALL = 8'h04;
  localparam gpc_byte_t GPC_RST_AFS = 8'h00;
  localparam gpc_byte_t GPC_RST_AFS_SMALL = 8'h04;
  localparam gpc_byte_t GPC_RST_ZERO = 8'h00;
  localparam gpc_byte_t GPC_RST_OUT = 8'h00;
  localparam gpc_byte_t GPC_RD_NONE = 8'h00;

endpackage : gpc_pkg

// ---- logic/gpc_port_cfg.sv ----
// general-purpose port pin configuration: registers, pin control and stop wake
`timescale 1ns/1ns
module gpc_port_cfg #(
  parameter int NUM_PORTS = 3,
  parameter bit SMALL_PKG = 1'b0
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register access
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire gpc_pkg::gpc_byte_t reg_wdata,
  output gpc_pkg::gpc_byte_t reg_rdata,
  // pins
  input wire logic [NUM_PORTS-1:0][7:0] pin_i,
  output logic [NUM_PORTS-1:0][7:0] pin_o,
  output logic [NUM_PORTS-1:0][7:0] pin_oe,
  output logic [NUM_PORTS-1:0][7:0] pin_high_drive,
  output logic [NUM_PORTS-1:0][7:0] pin_pullup_en,
  // alternate functions
  input wire logic [NUM_PORTS-1:0][3:0][7:0] alt_o,
  input wire logic [NUM_PORTS-1:0][3:0][7:0] alt_oe,
  output logic [NUM_PORTS-1:0][7:0] alt_active,
  output logic [NUM_PORTS-1:0][7:0] alt_sel_lo,
  output logic [NUM_PORTS-1:0][7:0] alt_sel_hi,
  // stop mode
  input wire logic stop_mode,
  output logic stop_recovery
);
  import gpc_pkg::*;

  localparam logic [9:0] BASE_WORD = GPC_BASE_ADDR[11:2];

  gpc_byte_t idx_a [NUM_PORTS];
  gpc_byte_t win_a [NUM_PORTS];
  gpc_byte_t out_a [NUM_PORTS];
  gpc_byte_t wake_a [NUM_PORTS];
  logic [NUM_PORTS-1:0] hit;

  logic [NUM_PORTS-1:0][7:0] pin_in_reg, pin_in_next;
  logic [NUM_PORTS-1:0][7:0] pin_o_reg, pin_o_next;
  logic [NUM_PORTS-1:0][7:0] pin_oe_reg, pin_oe_next;
  logic [NUM_PORTS-1:0][7:0] hd_reg, hd_next;
  logic [NUM_PORTS-1:0][7:0] pu_reg, pu_next;
  logic [NUM_PORTS-1:0][7:0] alt_act_reg, alt_act_next;
  logic [NUM_PORTS-1:0][7:0] sel_lo_reg, sel_lo_next;
  logic [NUM_PORTS-1:0][7:0] sel_hi_reg, sel_hi_next;
  gpc_byte_t rdata_reg, rdata_next;
  logic wake_reg, wake_next;

  // one bank per port, each behind its own address group
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    localparam gpc_byte_t AF_R = (SMALL_PKG && p == 0) ? GPC_RST_AF_SMALL : GPC_RST_AF;
    localparam gpc_byte_t AFS_R = (SMALL_PKG && p == 0) ? GPC_RST_AFS_SMALL : GPC_RST_AFS;
    localparam logic [9:0] MY_WORD = BASE_WORD + 10'(p);
    gpc_bank_if bif();

    assign hit[p] = (reg_addr[11:2] == MY_WORD);
    assign bif.wdata = reg_wdata;
    assign bif.idx_wr = reg_wr && hit[p] && reg_addr[1:0] == GPC_OFS_INDEX;
    assign bif.win_wr = reg_wr && hit[p] && reg_addr[1:0] == GPC_OFS_WINDOW;
    assign bif.out_wr = reg_wr && hit[p] && reg_addr[1:0] == GPC_OFS_OUTPUT;

    gpc_subreg_bank #(
      .AF_RST(AF_R),
      .AFS_RST(AFS_R)
    ) u_bank (
      .clock(clock),
      .sys_rst(sys_rst),
      .bus(bif.bank)
    );

    assign idx_a[p] = bif.index;
    assign win_a[p] = bif.win_rdata;
    assign out_a[p] = bif.outd;
    assign wake_a[p] = bif.wake;

    // per-pin drive decision
    always_comb begin
      logic [1:0] sel;
      logic val;
      logic en;
      sel = 2'b00;
      val = 1'b0;
      en = 1'b0;
      for (int b = 0; b < 8; b++) begin
        sel = {bif.afs_hi[b], bif.afs_lo[b]};
        if (bif.af[b]) begin
          val = alt_o[p][sel][b];
          en = alt_oe[p][sel][b];
        end else begin
          val = bif.outd[b];
          en = ~bif.dir[b];
        end
        pin_o_next[p][b] = val;
        // open drain releases a driven one, whoever is driving
        pin_oe_next[p][b] = en & ~(bif.oc[b] & val);
      end
      hd_next[p] = bif.hde;
      pu_next[p] = bif.pue;
      alt_act_next[p] = bif.af;
      sel_lo_next[p] = bif.afs_lo;
      sel_hi_next[p] = bif.afs_hi;
    end
  end

  // pins are sampled every cycle; input data reads the sample, wake compares the live pins with it
  always_comb begin
    pin_in_next = pin_i;
    wake_next = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (stop_mode && |((pin_i[p] ^ pin_in_reg[p]) & wake_a[p])) begin
        wake_next = 1'b1;
      end
    end
  end

  // read data registered; unmapped addresses read zero
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      rdata_next = GPC_RD_NONE;
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (hit[p]) begin
          unique case (reg_addr[1:0])
            GPC_OFS_INDEX: rdata_next = idx_a[p];
            GPC_OFS_WINDOW: rdata_next = win_a[p];
            GPC_OFS_INPUT: rdata_next = pin_in_reg[p];
            GPC_OFS_OUTPUT: rdata_next = out_a[p];
          endcase
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_in_reg <= '0;
      pin_o_reg <= '0;
      pin_oe_reg <= '0;
      hd_reg <= '0;
      pu_reg <= '0;
      alt_act_reg <= '0;
      sel_lo_reg <= '0;
      sel_hi_reg <= '0;
      rdata_reg <= GPC_RD_NONE;
      wake_reg <= 1'b0;
    end else begin
      pin_in_reg <= pin_in_next;
      pin_o_reg <= pin_o_next;
      pin_oe_reg <= pin_oe_next;
      hd_reg <= hd_next;
      pu_reg <= pu_next;
      alt_act_reg <= alt_act_next;
      sel_lo_reg <= sel_lo_next;
      sel_hi_reg <= sel_hi_next;
      rdata_reg <= rdata_next;
      wake_reg <= wake_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign pin_o = pin_o_reg;
  assign pin_oe = pin_oe_reg;
  assign pin_high_drive = hd_reg;
  assign pin_pullup_en = pu_reg;
  assign alt_active = alt_act_reg;
  assign alt_sel_lo = sel_lo_reg;
  assign alt_sel_hi = sel_hi_reg;
  assign stop_recovery = wake_reg;

endmodule : gpc_port_cfg

// ---- logic/gpc_subreg_bank.sv ----
// index register, output data and configuration sub-registers of one port
`timescale 1ns/1ns
module gpc_subreg_bank #(
  parameter gpc_pkg::gpc_byte_t AF_RST = gpc_pkg::GPC_RST_AF,
  parameter gpc_pkg::gpc_byte_t AFS_RST = gpc_pkg::GPC_RST_AFS
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // access from the top
  gpc_bank_if.bank bus
);
  import gpc_pkg::*;

  gpc_byte_t index_reg, index_next;
  gpc_byte_t dir_reg, dir_next;
  gpc_byte_t af_reg, af_next;
  gpc_byte_t oc_reg, oc_next;
  gpc_byte_t hde_reg, hde_next;
  gpc_byte_t wake_reg, wake_next;
  gpc_byte_t pue_reg, pue_next;
  gpc_byte_t afs_lo_reg, afs_lo_next;
  gpc_byte_t afs_hi_reg, afs_hi_next;
  gpc_byte_t out_reg, out_next;

  always_comb begin
    index_next = bus.idx_wr ? bus.wdata : index_reg;
    out_next = bus.out_wr ? bus.wdata : out_reg;
    dir_next = dir_reg;
    af_next = af_reg;
    oc_next = oc_reg;
    hde_next = hde_reg;
    wake_next = wake_reg;
    pue_next = pue_reg;
    afs_lo_next = afs_lo_reg;
    afs_hi_next = afs_hi_reg;
    // window writes land in the sub-register the index selects
    if (bus.win_wr) begin
      unique case (index_reg)
        GPC_IDX_DIR: dir_next = bus.wdata;
        GPC_IDX_AF: af_next = bus.wdata;
        GPC_IDX_OC: oc_next = bus.wdata;
        GPC_IDX_HDE: hde_next = bus.wdata;
        GPC_IDX_WAKE: wake_next = bus.wdata;
        GPC_IDX_PUE: pue_next = bus.wdata;
        GPC_IDX_AFS_LO: afs_lo_next = bus.wdata;
        GPC_IDX_AFS_HI: afs_hi_next = bus.wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (index_reg)
      GPC_IDX_DIR: bus.win_rdata = dir_reg;
      GPC_IDX_AF: bus.win_rdata = af_reg;
      GPC_IDX_OC: bus.win_rdata = oc_reg;
      GPC_IDX_HDE: bus.win_rdata = hde_reg;
      GPC_IDX_WAKE: bus.win_rdata = wake_reg;
      GPC_IDX_PUE: bus.win_rdata = pue_reg;
      GPC_IDX_AFS_LO: bus.win_rdata = afs_lo_reg;
      GPC_IDX_AFS_HI: bus.win_rdata = afs_hi_reg;
      default: bus.win_rdata = GPC_RD_NONE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      index_reg <= GPC_RST_INDEX;
      dir_reg <= GPC_RST_DIR;
      af_reg <= AF_RST;
      oc_reg <= GPC_RST_ZERO;
      hde_reg <= GPC_RST_ZERO;
      wake_reg <= GPC_RST_ZERO;
      pue_reg <= GPC_RST_ZERO;
      afs_lo_reg <= AFS_RST;
      afs_hi_reg <= AFS_RST;
      out_reg <= GPC_RST_OUT;
    end else begin
      index_reg <= index_next;
      dir_reg <= dir_next;
      af_reg <= af_next;
      oc_reg <= oc_next;
      hde_reg <= hde_next;
      wake_reg <= wake_next;
      pue_reg <= pue_next;
      afs_lo_reg <= afs_lo_next;
      afs_hi_reg <= afs_hi_next;
      out_reg <= out_next;
    end
  end

  assign bus.index = index_reg;
  assign bus.dir = dir_reg;
  assign bus.af = af_reg;
  assign bus.oc = oc_reg;
  assign bus.hde = hde_reg;
  assign bus.wake = wake_reg;
  assign bus.pue = pue_reg;
  assign bus.afs_lo = afs_lo_reg;
  assign bus.afs_hi = afs_hi_reg;
  assign bus.outd = out_reg;

endmodule : gpc_subreg_bank

// ---- test/gpc_pin_model.sv ----
// far side of the pins: external drivers, pull-ups and floating lines
`timescale 1ns/1ns
module gpc_pin_model #(
  parameter int NP = 3
) (
  // clock
  input wire logic clock,
  // from the block
  input wire logic [NP-1:0][7:0] pin_o,
  input wire logic [NP-1:0][7:0] pin_oe,
  input wire logic [NP-1:0][7:0] pin_pullup_en,
  // external drivers
  input wire logic [NP-1:0][7:0] ext_en,
  input wire logic [NP-1:0][7:0] ext_val,
  // resolved level
  output logic [NP-1:0][7:0] pin_i
);
  logic [7:0] float_reg = 8'h55;
  // undriven lines wander so a stale level never passes for a real one
  always @(posedge clock) float_reg <= ~float_reg;
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      pin_i[p] = (pin_oe[p] & pin_o[p]) | (~pin_oe[p] & ext_en[p] & ext_val[p])
        | (~pin_oe[p] & ~ext_en[p] & (pin_pullup_en[p] | float_reg));
    end
  end
endmodule : gpc_pin_model

// ---- test/gpc_port_cfg_assertions.sv ----
// port-level checks of the pin configuration block
`timescale 1ns/1ns
module gpc_port_cfg_assertions #(
  parameter int NUM_PORTS = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register access
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire gpc_pkg::gpc_byte_t reg_wdata,
  input wire gpc_pkg::gpc_byte_t reg_rdata,
  // pins and wake
  input wire logic [NUM_PORTS-1:0][7:0] pin_i,
  input wire logic [NUM_PORTS-1:0][7:0] pin_oe,
  input wire logic [NUM_PORTS-1:0][7:0] pin_high_drive,
  input wire logic [NUM_PORTS-1:0][7:0] pin_pullup_en,
  input wire logic stop_mode,
  input wire logic stop_recovery
);
  import gpc_pkg::*;
  gpc_byte_t idx0_reg;
  gpc_byte_t idx0_next;
  logic [11:0] end_addr;
  assign end_addr = GPC_BASE_ADDR + 12'(4 * NUM_PORTS);
  // only port 0 index is shadowed; other ports are left to the bench
  always_comb idx0_next = (reg_wr && reg_addr == GPC_BASE_ADDR) ? reg_wdata : idx0_reg;
  always_ff @(posedge clock) idx0_reg <= sys_rst ? GPC_RST_INDEX : idx0_next;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_read(logic [11:0] a);
    reg_rd && !reg_wr && reg_addr == a;
  endsequence
  sequence s_release;
    $fell(sys_rst);
  endsequence
  a_index_readback: assert property (s_read(GPC_BASE_ADDR) |=> reg_rdata == idx0_reg)
    else $error("index readback wrong");
  a_unmapped_read: assert property (reg_rd && (reg_addr < GPC_BASE_ADDR || reg_addr >= end_addr)
    |=> reg_rdata == GPC_RD_NONE) else $error("unmapped read not zero");
  a_empty_index: assert property (s_read(GPC_BASE_ADDR + 12'h1) ##0
    (idx0_reg == GPC_IDX_NONE || idx0_reg > GPC_IDX_AFS_HI) |=> reg_rdata == GPC_RD_NONE)
    else $error("empty index read not zero");
  a_rdata_stands: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  a_reset_quiet: assert property (s_release |-> pin_oe == '0 && !stop_recovery ##1 pin_oe == '0)
    else $error("pins driven after reset");
  a_reset_config: assert property (s_release |-> pin_high_drive == '0 && pin_pullup_en == '0)
    else $error("drive or pull-up set after reset");
  a_wake_cause: assert property (stop_recovery |-> $past(stop_mode) && $past(pin_i) != $past(pin_i, 2))
    else $error("recovery without stop edge");
  a_pins_need_write: assert property ($changed(pin_high_drive) || $changed(pin_pullup_en)
    |-> $past(reg_wr, 2)) else $error("drive config changed without write");
endmodule : gpc_port_cfg_assertions
bind gpc_port_cfg gpc_port_cfg_assertions #(.NUM_PORTS(NUM_PORTS)) gpc_port_cfg_assertions_i (
  .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_i(pin_i), .pin_oe(pin_oe),
  .pin_high_drive(pin_high_drive), .pin_pullup_en(pin_pullup_en), .stop_mode(stop_mode),
  .stop_recovery(stop_recovery));

// ---- test/gpc_port_cfg_test.sv ----
// random register and pin checks of the port configuration block
`timescale 1ns/1ns
module gpc_port_cfg_test;
  import gpc_pkg::*;
  localparam int NP = 3;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] reg_addr = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  gpc_byte_t reg_wdata = '0;
  gpc_byte_t reg_rdata;
  logic [NP-1:0][7:0] pin_i, pin_o, pin_oe, pin_high_drive, pin_pullup_en, alt_active, alt_sel_lo, alt_sel_hi;
  logic [NP-1:0][3:0][7:0] alt_o = '0;
  logic [NP-1:0][3:0][7:0] alt_oe = '0;
  logic [NP-1:0][7:0] ext_en = '0;
  logic [NP-1:0][7:0] ext_val = '0;
  logic stop_mode = 1'b0;
  logic stop_recovery;
  int seed = 35342;
  int mismatches = 0;
  int samples_checked = 0;
  gpc_byte_t sh [NP][9];
  gpc_byte_t sh_out [NP];
  gpc_byte_t tab [12] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h01, 8'h07, 8'h08, 8'h00, 8'h09, 8'hff, 8'h5a};
  always #50 clock = ~clock;
  gpc_port_cfg #(.NUM_PORTS(NP)) gpc_port_cfg_i (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe(pin_oe), .pin_high_drive(pin_high_drive), .pin_pullup_en(pin_pullup_en),
    .alt_o(alt_o), .alt_oe(alt_oe), .alt_active(alt_active), .alt_sel_lo(alt_sel_lo),
    .alt_sel_hi(alt_sel_hi), .stop_mode(stop_mode), .stop_recovery(stop_recovery));
  gpc_pin_model #(.NP(NP)) gpc_pin_model_i (.clock(clock), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i));
  function automatic logic [11:0] adr(int p, int o);
    return GPC_BASE_ADDR + 12'(4 * p + o);
  endfunction : adr
  function automatic gpc_byte_t exp_win(int p, gpc_byte_t i);
    return (i >= GPC_IDX_DIR && i <= GPC_IDX_AFS_HI) ? sh[p][i] : GPC_RD_NONE;
  endfunction : exp_win
  task automatic complete_run;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic check(input gpc_byte_t got, input gpc_byte_t exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input gpc_byte_t d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output gpc_byte_t d);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
  task automatic do_reset;
    @(negedge clock);
    sys_rst = 1'b1;
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    foreach (sh[p, i]) sh[p][i] = (i == 1) ? GPC_RST_DIR : GPC_RST_ZERO;
    foreach (sh_out[p]) sh_out[p] = GPC_RST_OUT;
  endtask : do_reset
  task automatic check_pins;
    gpc_byte_t ev;
    gpc_byte_t ee;
    for (int q = 0; q < NP; q++) begin
      ev = sh_out[q];
      ee = ~sh[q][1];
      for (int b = 0; b < 8; b++) begin
        if (sh[q][2][b]) begin
          ev[b] = alt_o[q][{sh[q][8][b], sh[q][7][b]}][b];
          ee[b] = alt_oe[q][{sh[q][8][b], sh[q][7][b]}][b];
        end
      end
      ee = ee & ~(sh[q][3] & ev);
      check(pin_oe[q], ee);
      check(pin_o[q] & ee, ev & ee);
      check(pin_high_drive[q], sh[q][4]);
      check(pin_pullup_en[q], sh[q][6]);
      check(alt_active[q], sh[q][2]);
      check(alt_sel_lo[q], sh[q][7]);
      check(alt_sel_hi[q], sh[q][8]);
    end
  endtask : check_pins
  initial begin
    #(100 * 30000);
    mismatches++;
    complete_run();
  end
  initial begin
    gpc_byte_t d;
    gpc_byte_t i;
    gpc_byte_t w;
    int p;
    int cnt;
    do_reset();
    for (p = 0; p < NP; p++) begin
      for (int k = 0; k < 9; k++) begin
        wr(adr(p, 0), 8'(k));
        rd(adr(p, 1), d);
        check(d, exp_win(p, 8'(k)));
      end
    end
    repeat (80) begin
      p = $unsigned($random(seed)) % NP;
      i = tab[$unsigned($random(seed)) % 12];
      d = 8'($random(seed));
      @(negedge clock);
      // every pin has an alternate function here, so any enable bit is legal
      alt_o = {$random(seed), $random(seed), $random(seed)};
      alt_oe = {$random(seed), $random(seed), $random(seed)};
      wr(adr(p, 0), i);
      wr(adr(p, 1), d);
      if (i >= GPC_IDX_DIR && i <= GPC_IDX_AFS_HI) sh[p][i] = d;
      sh_out[p] = 8'($random(seed));
      wr(adr(p, 3), sh_out[p]);
      wr(adr(p, 2), d);
      rd(adr(p, 0), d);
      check(d, i);
      rd(adr(p, 1), d);
      check(d, exp_win(p, i));
      rd(12'hfdc, d);
      check(d, GPC_RD_NONE);
      repeat (2) @(negedge clock);
      check_pins();
    end
    ext_en = '1;
    do_reset();
    // bits 0 and 4 forced on: a rising wake, a falling wake and a masked edge out of stop
    w = 8'($random(seed)) | 8'h11;
    wr(adr(1, 0), GPC_IDX_WAKE);
    wr(adr(1, 1), w);
    for (int b = 0; b < 16; b++) begin
      stop_mode = (b % 3 != 2);
      ext_val[1][b % 8] = ~ext_val[1][b % 8];
      cnt = 0;
      repeat (4) @(negedge clock) if (stop_recovery === 1'b1) cnt++;
      check(8'(cnt), 8'(w[b % 8] && stop_mode));
    end
    stop_mode = 1'b0;
    ext_val[1] = w;
    rd(adr(1, 2), d);
    check(d, w);
    complete_run();
  end
endmodule : gpc_port_cfg_test
